/* File: core/ebi_pkg.sv */
package ebi_pkg;

  localparam logic [7:0] OFS_ROUTING = 8'h00;
  localparam logic [7:0] OFS_PULLUP  = 8'h04;
  localparam logic [7:0] OFS_RSVD_A  = 8'h08;
  localparam logic [7:0] OFS_RSVD_B  = 8'h0C;
  localparam logic [7:0] OFS_SELCFG0 = 8'h10;
  localparam logic [7:0] OFS_SELCFG7 = 8'h2C;

  localparam int BIT_SEL0_ROUTE = 0;
  localparam int BIT_SEL1_ROUTE = 1;
  localparam int BIT_SEL3_NAND  = 3;
  localparam int BIT_SEL4_CARD  = 4;
  localparam int BIT_PULLUP_DIS = 0;

  localparam logic [1:0]  WIDTH_8      = 2'h2;
  localparam logic [1:0]  WIDTH_16     = 2'h1;
  localparam logic [1:0]  WIDTH_RESET  = WIDTH_16;
  localparam logic [31:0] ROUTE_RESET  = 32'h0000_0000;
  localparam logic [31:0] PULLUP_RESET = 32'h0000_0000;

  localparam int NUM_SELECTS = 8;
  localparam int PAGE_BITS   = 26;
  localparam int SPACE_BITS  = 29;

  typedef enum logic [1:0] {ACC_IDLE, ACC_STROBE, ACC_DONE} access_state_type;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic        ack;
    logic        handoff;
    logic        err;
    logic [15:0] rdata;
  } mem_rsp_type;

  typedef struct packed {
    logic [7:0]  chip_select_n;
    logic [25:1] addr;
    logic        addr0_low_byte_n;
    logic        read_strobe_n;
    logic        write_low_strobe_n;
    logic        write_high_strobe_n;
    logic [15:0] data_out;
    logic        data_oe_n;
    logic        data_pullup_en;
    logic        nand_read_strobe;
    logic        nand_write_strobe;
  } ext_pins_type;

  typedef struct packed {
    access_state_type st;
    logic [2:0]       sel;
    logic             eight;
    logic             we;
    logic [25:0]      addr;
    logic [1:0]       be;
    logic [15:0]      wdata;
    mem_rsp_type      rsp;
    logic             route0;
    logic             route1;
    logic             nand_en;
    logic             card_en;
    logic             pull_dis;
    logic [7:0][1:0]  width;
    logic             wb_ack;
    logic [31:0]      wb_dat;
  } ctrl_state_type;

endpackage

/* File: core/ebi_static_front.sv */
`timescale 1ns/1ps
module ebi_static_front (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire ebi_pkg::mem_req_type  mem_req_i,
  output ebi_pkg::mem_rsp_type       mem_rsp_o,
  output ebi_pkg::ext_pins_type      pins_o,
  input  wire logic [15:0]           data_i,
  input  wire logic                  wait_n_i,
  output logic                       sel0_burst_o,
  output logic                       sel1_sdram_o
);

  ebi_pkg::ctrl_state_type s_r;
  ebi_pkg::ctrl_state_type s_nxt;

  // Index of a per-select config word, or 8 when the offset is not one.
  function automatic logic [3:0] cfg_index(input logic [7:0] adr);
    logic [7:0] d;
    d = adr - ebi_pkg::OFS_SELCFG0;
    if (adr >= ebi_pkg::OFS_SELCFG0 && adr <= ebi_pkg::OFS_SELCFG7 && adr[1:0] == 2'h0) begin
      cfg_index = {1'b0, d[4:2]};
    end else begin
      cfg_index = 4'h8;
    end
  endfunction

  logic       wb_req;
  logic [3:0] ci;
  logic [2:0] req_sel;
  logic       req_eight;
  logic       claimed;

  assign wb_req    = wb_cyc_i && wb_stb_i;
  assign ci        = cfg_index(wb_adr_i);
  assign req_sel   = mem_req_i.addr[28:26];
  assign req_eight = (s_r.width[req_sel] == ebi_pkg::WIDTH_8);
  assign claimed   = (req_sel == 3'h0 && s_r.route0) || (req_sel == 3'h1 && s_r.route1);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.wb_ack  = 1'b0;
    s_nxt.rsp.ack = 1'b0;
    // Ack comes one cycle after the request; writes land on the edge that
    // the master samples ack, so a held request is never applied twice.
    if (wb_req && !s_r.wb_ack) begin
      s_nxt.wb_ack = 1'b1;
      s_nxt.wb_dat = 32'h0000_0000;
      if (wb_adr_i == ebi_pkg::OFS_ROUTING) begin
        s_nxt.wb_dat[ebi_pkg::BIT_SEL0_ROUTE] = s_r.route0;
        s_nxt.wb_dat[ebi_pkg::BIT_SEL1_ROUTE] = s_r.route1;
        s_nxt.wb_dat[ebi_pkg::BIT_SEL3_NAND]  = s_r.nand_en;
        s_nxt.wb_dat[ebi_pkg::BIT_SEL4_CARD]  = s_r.card_en;
      end else if (wb_adr_i == ebi_pkg::OFS_PULLUP) begin
        s_nxt.wb_dat[ebi_pkg::BIT_PULLUP_DIS] = s_r.pull_dis;
      end else if (!ci[3]) begin
        s_nxt.wb_dat[1:0] = s_r.width[ci[2:0]];
      end
    end
    if (wb_req && s_r.wb_ack && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == ebi_pkg::OFS_ROUTING) begin
        s_nxt.route0  = wb_dat_i[ebi_pkg::BIT_SEL0_ROUTE];
        s_nxt.route1  = wb_dat_i[ebi_pkg::BIT_SEL1_ROUTE];
        s_nxt.nand_en = wb_dat_i[ebi_pkg::BIT_SEL3_NAND];
        s_nxt.card_en = wb_dat_i[ebi_pkg::BIT_SEL4_CARD];
      end else if (wb_adr_i == ebi_pkg::OFS_PULLUP) begin
        s_nxt.pull_dis = wb_dat_i[ebi_pkg::BIT_PULLUP_DIS];
      end else if (!ci[3]) begin
        s_nxt.width[ci[2:0]] = wb_dat_i[1:0];
      end
    end

    unique case (s_r.st)
      ebi_pkg::ACC_IDLE: begin
        if (mem_req_i.valid) begin
          s_nxt.sel   = req_sel;
          s_nxt.eight = req_eight;
          s_nxt.we    = mem_req_i.we;
          // Low page bits pass straight out, so a small device aliases.
          s_nxt.addr  = mem_req_i.addr[25:0];
          s_nxt.be    = mem_req_i.be;
          s_nxt.wdata = mem_req_i.wdata;
          s_nxt.rsp.handoff = claimed;
          s_nxt.rsp.err     = |mem_req_i.addr[31:29];
          if (claimed || |mem_req_i.addr[31:29]) begin
            s_nxt.st = ebi_pkg::ACC_DONE;
          end else begin
            s_nxt.st = ebi_pkg::ACC_STROBE;
          end
        end
      end
      ebi_pkg::ACC_STROBE: begin
        if (wait_n_i) begin
          s_nxt.st = ebi_pkg::ACC_DONE;
          if (s_r.eight && s_r.addr[0]) begin
            s_nxt.rsp.rdata = {data_i[7:0], 8'h00};
          end else if (s_r.eight) begin
            s_nxt.rsp.rdata = {8'h00, data_i[7:0]};
          end else begin
            s_nxt.rsp.rdata = data_i;
          end
        end
      end
      ebi_pkg::ACC_DONE: begin
        s_nxt.rsp.ack = 1'b1;
        s_nxt.st      = ebi_pkg::ACC_IDLE;
      end
      default: begin
        s_nxt.st = ebi_pkg::ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.st       <= ebi_pkg::ACC_IDLE;
      s_r.route0   <= ebi_pkg::ROUTE_RESET[ebi_pkg::BIT_SEL0_ROUTE];
      s_r.route1   <= ebi_pkg::ROUTE_RESET[ebi_pkg::BIT_SEL1_ROUTE];
      s_r.nand_en  <= ebi_pkg::ROUTE_RESET[ebi_pkg::BIT_SEL3_NAND];
      s_r.card_en  <= ebi_pkg::ROUTE_RESET[ebi_pkg::BIT_SEL4_CARD];
      s_r.pull_dis <= ebi_pkg::PULLUP_RESET[ebi_pkg::BIT_PULLUP_DIS];
      s_r.width    <= {ebi_pkg::NUM_SELECTS{ebi_pkg::WIDTH_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic       strobe;
  logic [7:0] onehot;
  logic       card_acc;

  assign strobe   = (s_r.st == ebi_pkg::ACC_STROBE);
  assign onehot   = strobe ? (8'h01 << s_r.sel) : 8'h00;
  assign card_acc = s_r.card_en && onehot[4];

  always_comb begin
    pins_o = '0;
    pins_o.chip_select_n = ~onehot;
    if (s_r.card_en) begin
      // Selects 5 and 6 become card enables for the low and high byte;
      // their own regions are left undriven, which software must avoid.
      pins_o.chip_select_n[5] = ~(card_acc && s_r.be[0]);
      pins_o.chip_select_n[6] = ~(card_acc && s_r.be[1]);
    end
    pins_o.addr = s_r.addr[25:1];
    // 8-bit devices take the byte address, 16-bit ones the low-byte select.
    pins_o.addr0_low_byte_n    = s_r.eight ? s_r.addr[0] : ~(strobe && s_r.be[0]);
    pins_o.read_strobe_n       = ~(strobe && !s_r.we);
    pins_o.write_low_strobe_n  = ~(strobe && s_r.we && (s_r.eight || s_r.be[0]));
    pins_o.write_high_strobe_n = ~(strobe && s_r.we && !s_r.eight && s_r.be[1]);
    if (s_r.eight && s_r.addr[0]) begin
      pins_o.data_out = {8'h00, s_r.wdata[15:8]};
    end else begin
      pins_o.data_out = s_r.wdata;
    end
    pins_o.data_oe_n         = ~(strobe && s_r.we);
    pins_o.data_pullup_en    = ~s_r.pull_dis;
    pins_o.nand_read_strobe  = s_r.nand_en && onehot[3] && !s_r.we;
    pins_o.nand_write_strobe = s_r.nand_en && onehot[3] && s_r.we;
  end

  assign mem_rsp_o    = s_r.rsp;
  assign wb_ack_o     = s_r.wb_ack;
  assign wb_dat_o     = s_r.wb_dat;
  assign sel0_burst_o = s_r.route0;
  assign sel1_sdram_o = s_r.route1;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    (s_r.st == ebi_pkg::ACC_IDLE) && mem_req_i.valid;
  endsequence
  sequence s_finish;
    ##[1:300] mem_rsp_o.ack;
  endsequence

  a_access_completes: assert property (
    (s_start and wait_n_i) ##1 wait_n_i |-> ##[1:2] mem_rsp_o.ack)
    else $error("Access did not complete with wait released.");
  a_wait_stretches: assert property (
    strobe && !wait_n_i |=> strobe && !mem_rsp_o.ack)
    else $error("Wait low did not hold the access.");
  a_route0_claims: assert property (
    (s_start and (req_sel == 3'h0 && s_r.route0)) |=> !strobe ##1 mem_rsp_o.handoff)
    else $error("Select 0 not handed to burst flash.");
  a_route1_pin: assert property (
    s_r.route1 |-> pins_o.chip_select_n[1])
    else $error("Select 1 pin driven while routed to SDRAM.");
  a_nand_window: assert property (
    (pins_o.nand_read_strobe || pins_o.nand_write_strobe) |->
      !pins_o.chip_select_n[3] && s_r.nand_en)
    else $error("NAND strobe outside select 3.");
  a_card_pins: assert property (
    s_r.card_en && strobe && s_r.sel != 3'h4 |-> &pins_o.chip_select_n[6:4])
    else $error("Card pins active outside the card region.");
  a_pullup_follows: assert property (
    wb_req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ebi_pkg::OFS_PULLUP
      |=> pins_o.data_pullup_en == !$past(wb_dat_i[0]))
    else $error("Pull-up pin does not follow config.");
  a_width8_addr0: assert property (
    strobe && s_r.eight |-> pins_o.addr0_low_byte_n == s_r.addr[0]
      && pins_o.write_high_strobe_n)
    else $error("8-bit access misuses A0 or high strobe.");
  a_width16_lowbyte: assert property (
    (s_start and (!req_eight && !claimed && mem_req_i.addr[31:29] == 3'h0 && mem_req_i.be[0]))
      |=> !pins_o.addr0_low_byte_n)
    else $error("16-bit low-byte select not asserted.");
  a_reserved_zero: assert property (
    wb_req && !wb_ack_o && wb_adr_i == ebi_pkg::OFS_ROUTING
      |=> wb_ack_o && wb_dat_o[31:5] == 27'h0 && !wb_dat_o[2])
    else $error("Undefined routing bits not zero.");
  a_out_of_space: assert property (
    (s_start and (|mem_req_i.addr[31:29])) |=> !strobe ##1 mem_rsp_o.err && mem_rsp_o.ack)
    else $error("Address above 512 MB not refused.");
  a_single_select: assert property (
    !s_r.card_en |-> $countones(~pins_o.chip_select_n) <= 1)
    else $error("More than one select active.");

endmodule // ebi_static_front

/* File: verif/ebi_assign_static_mem_map_tb_top.sv */
`timescale 1ns/1ps
module ebi_assign_static_mem_map_tb_top;
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [31:0] ex;} row_type;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  wb_req, wb_we, wb_ack, sel0_burst, sel1_sdram, wait_n, seen_nand, seen_a0;
  logic [7:0]            wb_adr, seen_cs;
  logic [31:0]           wb_dat_w, wb_dat_r, rd_v;
  logic [15:0]           data_in;
  logic [3:0]            waits = 4'h0;
  ebi_pkg::mem_req_type  req, mreq;
  ebi_pkg::mem_rsp_type  rsp, got;
  ebi_pkg::ext_pins_type pins;
  int                    err_total = 0, tests_run = 0, cycles = 0, n;
  row_type rows [9] = '{'{8'h00, 32'hFFFFFFFF, 32'h1B}, '{8'h04, 32'hFFFFFFFF, 32'h1},
    '{8'h08, 32'hFFFFFFFF, 32'h0}, '{8'h0C, 32'hFFFFFFFF, 32'h0}, '{8'h60, 32'hFF, 32'h0},
    '{8'h10, 32'hFFFFFFFF, 32'h3}, '{8'h10, 32'h1, 32'h1}, '{8'h00, 32'h0, 32'h0},
    '{8'h04, 32'h0, 32'h0}};
  always_comb begin
    mreq = req;
    mreq.valid = req.valid && !rsp.ack;
  end
  ebi_static_front DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .mem_req_i(mreq), .mem_rsp_o(rsp), .pins_o(pins),
    .data_i(data_in), .wait_n_i(wait_n), .sel0_burst_o(sel0_burst), .sel1_sdram_o(sel1_sdram));
  ext_static_mem_model partner (.pins_i(pins), .clk_i(clk_i), .waits_i(waits),
    .data_o(data_in), .wait_n_o(wait_n));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_req <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd_v = wb_dat_r;
    wb_req <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic mem_op(input logic we, input logic [31:0] adr);
    @(posedge clk_i);
    req <= '{1'b1, we, adr, 2'h3, 16'hA55A};
    seen_cs = 8'h00;
    seen_nand = 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      seen_cs |= ~pins.chip_select_n;
      seen_nand |= pins.nand_read_strobe | pins.nand_write_strobe;
      if (!pins.read_strobe_n) seen_a0 = pins.addr0_low_byte_n;
    end while (rsp.ack !== 1'b1);
    @(posedge clk_i);
    got = rsp;
    req.valid <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      results();
    end
  end
  initial begin
    wb_req = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_w = 32'h0;
    req = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check({pins.chip_select_n, pins.read_strobe_n, pins.data_pullup_en}, 32'h3FF);
    foreach (rows[i]) begin
      wb_xfer(1'b1, rows[i].adr, rows[i].wd);
      wb_xfer(1'b0, rows[i].adr, 32'h0);
      check(rd_v, rows[i].ex);
    end
    for (int i = 0; i < 2; i++) begin
      wb_xfer(1'b1, 8'h00, 32'h1 << i);
      check({sel1_sdram, sel0_burst}, 32'h1 << i);
      mem_op(1'b0, 32'(i) << 26);
      check({got.handoff, seen_cs}, 32'h100);
    end
    wb_xfer(1'b1, 8'h00, 32'h0);
    mem_op(1'b1, 32'h0800_0006);
    waits <= 4'h2;
    mem_op(1'b0, 32'h0800_0006);
    check(got.rdata, 32'hA55A);
    check(n, 32'h6);
    check({seen_cs, seen_a0}, 32'h8);
    waits <= 4'h0;
    mem_op(1'b0, 32'h0800_0026);
    check(got.rdata, 32'hA55A);
    mem_op(1'b0, 32'h2000_0000);
    check({got.err, seen_cs}, 32'h100);
    mem_op(1'b0, 32'h1FFF_FFFE);
    check(seen_cs, 32'h80);
    wb_xfer(1'b1, 8'h00, 32'h8);
    mem_op(1'b0, 32'h0C00_0000);
    check(seen_nand, 32'h1);
    mem_op(1'b0, 32'h0800_0000);
    check(seen_nand, 32'h0);
    // Card mode stays clear of regions 5 and 6 on purpose.
    wb_xfer(1'b1, 8'h00, 32'h10);
    mem_op(1'b0, 32'h1000_0000);
    check(seen_cs, 32'h70);
    wb_xfer(1'b1, 8'h00, 32'h1);
    wb_xfer(1'b1, 8'h18, 32'h2);
    for (int i = 0; i < 2; i++) begin
      mem_op(1'b0, 32'h0800_0002 + i);
      check(seen_a0, 32'(i));
    end
    wb_xfer(1'b1, 8'h04, 32'h1);
    check(pins.data_pullup_en, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check({sel0_burst, pins.data_pullup_en, pins.chip_select_n}, 32'h1FF);
    wb_xfer(1'b0, 8'h18, 32'h0);
    check(rd_v, 32'h1);
    results();
  end
endmodule // ebi_assign_static_mem_map_tb_top

/* File: verif/ext_static_mem_model.sv */
`timescale 1ns/1ps
module ext_static_mem_model (
  input  wire ebi_pkg::ext_pins_type pins_i,
  input  wire logic                  clk_i,
  input  wire logic [3:0]            waits_i,
  output logic      [15:0]           data_o,
  output logic                       wait_n_o
);
  // Sixteen words only, so a larger page wraps onto them like a small part.
  logic [15:0] mem [16];
  logic [15:0] last_r = 16'h0000;
  logic [3:0]  cnt_r = 4'h0;
  logic        rd;
  logic        wr;
  logic [3:0]  idx;
  assign idx = pins_i.addr[4:1];
  assign rd = (pins_i.chip_select_n != 8'hFF) && !pins_i.read_strobe_n;
  assign wr = (pins_i.chip_select_n != 8'hFF) &&
              !(pins_i.write_low_strobe_n && pins_i.write_high_strobe_n);
  assign wait_n_o = !(rd || wr) || (cnt_r >= waits_i);
  // A released bus floats to the pull-up level, or else shows a stale inverse.
  assign data_o = rd ? mem[idx] : (pins_i.data_pullup_en ? 16'hFFFF : ~last_r);
  always @(posedge clk_i) begin
    cnt_r <= (rd || wr) ? cnt_r + 4'h1 : 4'h0;
    if (rd) begin
      last_r <= mem[idx];
    end
    if (wr && wait_n_o && !pins_i.write_low_strobe_n) begin
      mem[idx][7:0] <= pins_i.data_out[7:0];
    end
    if (wr && wait_n_o && !pins_i.write_high_strobe_n) begin
      mem[idx][15:8] <= pins_i.data_out[15:8];
    end
  end
endmodule // ext_static_mem_model
